// file: design/pcg_pkg.sv
`default_nettype none
package pcg_pkg;
  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_RUN_GATE_REG0        = 12'h100;
  localparam logic [11:0] OFS_RUN_GATE_REG1        = 12'h104;
  localparam logic [11:0] OFS_SLEEP_GATE_REG0      = 12'h110;
  localparam logic [11:0] OFS_SLEEP_GATE_REG1      = 12'h114;
  localparam logic [11:0] OFS_DEEP_SLEEP_GATE_REG0 = 12'h120;
  localparam logic [11:0] OFS_DEEP_SLEEP_GATE_REG1 = 12'h124;
  localparam logic [11:0] OFS_RUN_CLOCK_CONFIG_REG = 12'h140;
  localparam logic [11:0] OFS_FAULT_STATUS         = 12'h150;
  localparam logic [11:0] OFS_FAULT_MASK           = 12'h154;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int BIT_HIBERNATION_GATE   = 6;
  localparam int BIT_WATCHDOG_GATE      = 3;
  localparam int BIT_COMPARATOR_ONE     = 25;
  localparam int BIT_COMPARATOR_ZERO    = 24;
  localparam int BIT_GP_TIMER_THREE     = 19;
  localparam int BIT_AUTO_GATING_SELECT = 0;
  // ------------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] MASK_GATE_REG0  = 32'h0000_0048;
  localparam logic [31:0] MASK_GATE_REG1  = 32'h0308_0000;
  localparam logic [31:0] MASK_CLOCK_CFG  = 32'h0000_0001;
  localparam logic [31:0] MASK_FAULT      = 32'h0000_001f;
  localparam logic [31:0] RST_GATE_REG0   = 32'h0000_0040;
  localparam logic [31:0] RST_GATE_REG1   = 32'h0000_0000;
  localparam logic [31:0] RST_CLOCK_CFG   = 32'h0000_0000;
  localparam logic [31:0] RST_FAULT       = 32'h0000_0000;
  // ------------------------------------------------------------------
  // unit index: hibernation, watchdog, comparator 0, comparator 1, timer 3
  // ------------------------------------------------------------------
  localparam int NUM_UNITS      = 5;
  localparam int UNIT_HIB       = 0;
  localparam int UNIT_WDT       = 1;
  localparam int UNIT_COMPARATOR_ZERO_GATE     = 2;
  localparam int UNIT_COMPARATOR_ONE_GATE     = 3;
  localparam int UNIT_GP_TIMER_THREE_GATE    = 4;
  // ------------------------------------------------------------------
  // operating modes
  // ------------------------------------------------------------------
  typedef enum logic [2:0]
  {
    PCG_MODE_RUN   = 3'b001,
    PCG_MODE_SLEEP = 3'b010,
    PCG_MODE_DEEP  = 3'b100
  } pcg_mode_t;
endpackage
`default_nettype wire

// file: design/pcg_top.sv
// What this block does
// (RQ1) A set gating bit passes the running clock to its unit and a clear bit stops it.
// (RQ2) An access aimed at a unit whose gate is off is answered with a bus fault.
// (RQ3) Gating bits reset cleared unless a bit has its own documented reset value.
// (RQ4) Run, sleep and deep-sleep gating sets exist and the one for the current mode applies.
// (RQ5) Sleep and deep-sleep sets only apply while the auto gating select bit is set.
// (RQ6) Deep-sleep gating register 0 is at 0x120, 32 bits wide, reset 0x00000040.
// (RQ7) Bit 6 of deep-sleep gating register 0 is read/write and gates hibernation in deep sleep.
// (RQ8) Bit 3 of deep-sleep gating register 0 is read/write and gates the watchdog.
// (RQ9) Software keeps reserved bits as read when doing read-modify-write.
// (RQ10) Run gating register 1 is at 0x104, 32 bits wide, reset 0x00000000.
// (RQ11) Run gating register 1 bit 25 gates comparator 1 and bit 24 gates comparator 0.
// (RQ12) Run gating register 1 bit 19 gates timer 3 and bits 31:26 and 23:20 read zero.
// (RQ13) The hibernation gating bit resets to one as the whole-register value says.
// (RQ14) Reserved gating bits ignore writes and read as zero.
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module pcg_top
  import pcg_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_rst_b,
  input  wire logic [11:0]          i_addr,
  input  wire logic [31:0]          i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [31:0]          o_rdata,
  input  wire logic                 i_sleep_enter,
  input  wire logic                 i_deep_enter,
  input  wire logic                 i_wake,
  input  wire logic [NUM_UNITS-1:0] i_unit_access,
  output logic      [NUM_UNITS-1:0] o_bus_fault,
  output logic      [NUM_UNITS-1:0] o_unit_ack,
  output logic      [NUM_UNITS-1:0] o_gate_en,
  output logic      [NUM_UNITS-1:0] o_unit_clock,
  output logic      [2:0]           o_mode,
  output logic                      o_irq
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic       rst_meta_r;
  logic       rst_sync_r;

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] masked_write(input logic [31:0] cur,
                                               input logic [31:0] wdata,
                                               input logic [31:0] mask);
    masked_write = (wdata & mask) | (cur & ~mask);
  endfunction

  function automatic logic [NUM_UNITS-1:0] unit_bits(input logic [31:0] reg0,
                                                     input logic [31:0] reg1);
    unit_bits = {reg1[BIT_GP_TIMER_THREE], reg1[BIT_COMPARATOR_ONE],
                 reg1[BIT_COMPARATOR_ZERO], reg0[BIT_WATCHDOG_GATE],
                 reg0[BIT_HIBERNATION_GATE]};
  endfunction

  function automatic logic wr_hit(input logic        wr,
                                  input logic [11:0] addr,
                                  input logic [11:0] ofs);
    wr_hit = wr && (addr == ofs);
  endfunction

  localparam logic [NUM_UNITS-1:0] RST_GATE_EN = unit_bits(RST_GATE_REG0, RST_GATE_REG1);

  // ------------------------------------------------------------------
  // write strobes
  // ------------------------------------------------------------------
  logic wr_run0;
  logic wr_run1;
  logic wr_slp0;
  logic wr_slp1;
  logic wr_dsl0;
  logic wr_dsl1;
  logic wr_cfg;
  logic wr_stat;
  logic wr_mask;

  assign wr_run0 = wr_hit(i_wr, i_addr, OFS_RUN_GATE_REG0);
  assign wr_run1 = wr_hit(i_wr, i_addr, OFS_RUN_GATE_REG1);
  assign wr_slp0 = wr_hit(i_wr, i_addr, OFS_SLEEP_GATE_REG0);
  assign wr_slp1 = wr_hit(i_wr, i_addr, OFS_SLEEP_GATE_REG1);
  assign wr_dsl0 = wr_hit(i_wr, i_addr, OFS_DEEP_SLEEP_GATE_REG0); // RQ6
  assign wr_dsl1 = wr_hit(i_wr, i_addr, OFS_DEEP_SLEEP_GATE_REG1);
  assign wr_cfg  = wr_hit(i_wr, i_addr, OFS_RUN_CLOCK_CONFIG_REG);
  assign wr_stat = wr_hit(i_wr, i_addr, OFS_FAULT_STATUS);
  assign wr_mask = wr_hit(i_wr, i_addr, OFS_FAULT_MASK);

  // ------------------------------------------------------------------
  // gating registers
  // ------------------------------------------------------------------
  logic [31:0] run_gate_reg0_r;
  logic [31:0] run_gate_reg1_r;
  logic [31:0] sleep_gate_reg0_r;
  logic [31:0] sleep_gate_reg1_r;
  logic [31:0] deep_sleep_gate_reg0_r;
  logic [31:0] deep_sleep_gate_reg1_r;
  logic [31:0] run_clock_config_reg_r;

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      run_gate_reg0_r <= RST_GATE_REG0; // RQ3
    else if (wr_run0)
      run_gate_reg0_r <= masked_write(run_gate_reg0_r, i_wdata, MASK_GATE_REG0); // RQ14
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      sleep_gate_reg0_r <= RST_GATE_REG0; // RQ13
    else if (wr_slp0)
      sleep_gate_reg0_r <= masked_write(sleep_gate_reg0_r, i_wdata, MASK_GATE_REG0);
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      deep_sleep_gate_reg0_r <= RST_GATE_REG0; // RQ6
    else if (wr_dsl0)
      deep_sleep_gate_reg0_r <= masked_write(deep_sleep_gate_reg0_r, i_wdata,
                                             MASK_GATE_REG0); // RQ7
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      run_gate_reg1_r <= RST_GATE_REG1; // RQ10
    else if (wr_run1)
      run_gate_reg1_r <= masked_write(run_gate_reg1_r, i_wdata, MASK_GATE_REG1); // RQ12
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      sleep_gate_reg1_r <= RST_GATE_REG1;
    else if (wr_slp1)
      sleep_gate_reg1_r <= masked_write(sleep_gate_reg1_r, i_wdata, MASK_GATE_REG1);
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      deep_sleep_gate_reg1_r <= RST_GATE_REG1;
    else if (wr_dsl1)
      deep_sleep_gate_reg1_r <= masked_write(deep_sleep_gate_reg1_r, i_wdata, MASK_GATE_REG1);
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      run_clock_config_reg_r <= RST_CLOCK_CFG;
    else if (wr_cfg)
      run_clock_config_reg_r <= masked_write(run_clock_config_reg_r, i_wdata,
                                             MASK_CLOCK_CFG);
  end

  // ------------------------------------------------------------------
  // operating mode
  // ------------------------------------------------------------------
  pcg_mode_t mode_r;
  pcg_mode_t mode_nxt;

  always_comb
  begin
    mode_nxt = mode_r;
    case (mode_r)
      PCG_MODE_RUN:
      begin
        if (i_deep_enter)
          mode_nxt = PCG_MODE_DEEP;
        else if (i_sleep_enter)
          mode_nxt = PCG_MODE_SLEEP;
      end
      PCG_MODE_SLEEP:
      begin
        if (i_wake)
          mode_nxt = PCG_MODE_RUN;
      end
      PCG_MODE_DEEP:
      begin
        if (i_wake)
          mode_nxt = PCG_MODE_RUN;
      end
      default:
        mode_nxt = PCG_MODE_RUN;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      mode_r <= PCG_MODE_RUN;
    else
      mode_r <= mode_nxt;
  end

  // ------------------------------------------------------------------
  // gate selection
  // ------------------------------------------------------------------
  logic                 auto_gating_select;
  logic [NUM_UNITS-1:0] gate_sel;
  logic [NUM_UNITS-1:0] gate_en_r;

  assign auto_gating_select = run_clock_config_reg_r[BIT_AUTO_GATING_SELECT];

  always_comb
  begin
    gate_sel = unit_bits(run_gate_reg0_r, run_gate_reg1_r);
    if (auto_gating_select) // RQ5
    begin
      case (mode_r)
        PCG_MODE_SLEEP:
          gate_sel = unit_bits(sleep_gate_reg0_r, sleep_gate_reg1_r); // RQ4
        PCG_MODE_DEEP:
          gate_sel = unit_bits(deep_sleep_gate_reg0_r, deep_sleep_gate_reg1_r); // RQ4
        default:
          gate_sel = unit_bits(run_gate_reg0_r, run_gate_reg1_r); // RQ11
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      gate_en_r <= RST_GATE_EN; // RQ3
    else
      gate_en_r <= gate_sel;
  end

  // ------------------------------------------------------------------
  // clock gates
  // ------------------------------------------------------------------
  logic [NUM_UNITS-1:0] gate_latch;

  always_latch
  begin
    if (!i_clock)
      gate_latch <= gate_en_r;
  end

  assign o_unit_clock = {NUM_UNITS{i_clock}} & gate_latch; // RQ1

  // ------------------------------------------------------------------
  // state outputs
  // ------------------------------------------------------------------
  assign o_gate_en = gate_en_r;
  assign o_mode    = mode_r;

  // ------------------------------------------------------------------
  // peripheral access check
  // ------------------------------------------------------------------
  assign o_bus_fault = i_unit_access & ~gate_en_r; // RQ2 RQ8
  assign o_unit_ack  = i_unit_access & gate_en_r; // RQ2

  // ------------------------------------------------------------------
  // fault status and interrupt
  // ------------------------------------------------------------------
  logic [31:0] fault_status_r;
  logic [31:0] fault_status_nxt;
  logic [31:0] fault_mask_r;
  logic [31:0] fault_set;

  assign fault_set = {{(32-NUM_UNITS){1'b0}}, o_bus_fault};

  always_comb
  begin
    fault_status_nxt = fault_status_r | fault_set;
    if (wr_stat)
      fault_status_nxt = (fault_status_r & ~i_wdata) | fault_set;
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      fault_status_r <= RST_FAULT;
    else
      fault_status_r <= fault_status_nxt & MASK_FAULT;
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      fault_mask_r <= RST_FAULT;
    else if (wr_mask)
      fault_mask_r <= masked_write(fault_mask_r, i_wdata, MASK_FAULT);
  end

  assign o_irq = |(fault_status_r & fault_mask_r);

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;

  always_comb
  begin
    case (i_addr)
      OFS_RUN_GATE_REG0:        rdata_nxt = run_gate_reg0_r;
      OFS_RUN_GATE_REG1:        rdata_nxt = run_gate_reg1_r; // RQ12
      OFS_SLEEP_GATE_REG0:      rdata_nxt = sleep_gate_reg0_r;
      OFS_SLEEP_GATE_REG1:      rdata_nxt = sleep_gate_reg1_r;
      OFS_DEEP_SLEEP_GATE_REG0: rdata_nxt = deep_sleep_gate_reg0_r; // RQ14
      OFS_DEEP_SLEEP_GATE_REG1: rdata_nxt = deep_sleep_gate_reg1_r;
      OFS_RUN_CLOCK_CONFIG_REG: rdata_nxt = run_clock_config_reg_r;
      OFS_FAULT_STATUS:         rdata_nxt = fault_status_r;
      OFS_FAULT_MASK:           rdata_nxt = fault_mask_r;
      default:                  rdata_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      rdata_r <= 32'h0000_0000;
    else if (i_rd)
      rdata_r <= rdata_nxt;
    else
      rdata_r <= 32'h0000_0000;
  end

  assign o_rdata = rdata_r;

endmodule
`default_nettype wire

// file: testbench/pcg_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pcg_chk
  import pcg_pkg::*;
(
  input wire logic        i_clock,
  input wire logic        i_rst_b,
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_sleep_enter,
  input wire logic        i_deep_enter,
  input wire logic        i_wake,
  input wire logic [4:0]  i_unit_access,
  input wire logic [4:0]  o_bus_fault,
  input wire logic [4:0]  o_unit_ack,
  input wire logic [4:0]  o_gate_en,
  input wire logic [4:0]  o_unit_clock,
  input wire logic [2:0]  o_mode,
  input wire logic        o_irq
);
  // --------
  // checks
  // --------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  wire logic w1 = i_wr && i_addr == OFS_RUN_GATE_REG1;
  sequence s_wr1;
    w1 && o_mode == PCG_MODE_RUN;
  endsequence
  sequence s_quiet;
    !w1 && o_mode == PCG_MODE_RUN && !i_sleep_enter && !i_deep_enter;
  endsequence
  property p_gate;
    logic [31:0] v;
    (s_wr1, v = i_wdata) ##1 s_quiet |=> o_gate_en[4:2] == {v[19], v[25], v[24]};
  endproperty
  a_gate: assert property (p_gate) else $error("run gate mismatch");
  property p_fault;
    o_bus_fault == (i_unit_access & ~o_gate_en);
  endproperty
  a_fault: assert property (p_fault) else $error("bus fault mismatch");
  property p_ack;
    o_unit_ack == (i_unit_access & o_gate_en);
  endproperty
  a_ack: assert property (p_ack) else $error("unit ack mismatch");
  property p_rsv1;
    i_rd && i_addr == OFS_RUN_GATE_REG1 |=> (o_rdata & 32'hfcf7_ffff) == 32'h0;
  endproperty
  a_rsv1: assert property (p_rsv1) else $error("reg1 reserved bits set");
  property p_rsv0;
    i_rd && i_addr == OFS_DEEP_SLEEP_GATE_REG0 |=> (o_rdata & 32'hffff_ffb7) == 32'h0;
  endproperty
  a_rsv0: assert property (p_rsv0) else $error("reg0 reserved bits set");
  property p_sleep;
    o_mode == PCG_MODE_RUN && i_sleep_enter && !i_deep_enter |=> o_mode == PCG_MODE_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
  property p_deep;
    o_mode == PCG_MODE_RUN && i_deep_enter |=> o_mode == PCG_MODE_DEEP;
  endproperty
  a_deep: assert property (p_deep) else $error("deep entry wrong");
  property p_wake;
    o_mode != PCG_MODE_RUN && i_wake |=> o_mode == PCG_MODE_RUN;
  endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
  property p_uclk;
    @(negedge i_clock) o_unit_clock == $past(o_gate_en);
  endproperty
  a_uclk: assert property (p_uclk) else $error("unit clock wrong");
  property p_irq;
    $rose(o_irq) |-> $past(i_wr) || $past(o_bus_fault) != 5'h0;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without cause");
endmodule
`default_nettype wire

// file: testbench/pcg_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module pcg_top_tb;
  import pcg_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [2:0]  pul = 3'h0;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic [4:0]  acc = 5'h0;
  logic [31:0] rdata, d, v;
  logic [4:0]  flt, ack, gen, uclk;
  logic [2:0]  mode;
  logic        irq;
  logic [31:0] sh [6];
  logic [11:0] ofs [9] = '{12'h100, 12'h104, 12'h110, 12'h114, 12'h120, 12'h124,
                           12'h140, 12'h150, 12'h154};
  int          num_errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  int          k;
  pcg_top i_dut (
    .i_clock       (clk),
    .i_rst_b       (rst_b),
    .i_addr        (addr),
    .i_wdata       (wdata),
    .i_wr          (wr),
    .i_rd          (rd),
    .o_rdata       (rdata),
    .i_sleep_enter (pul[0]),
    .i_deep_enter  (pul[1]),
    .i_wake        (pul[2]),
    .i_unit_access (acc),
    .o_bus_fault   (flt),
    .o_unit_ack    (ack),
    .o_gate_en     (gen),
    .o_unit_clock  (uclk),
    .o_mode        (mode),
    .o_irq         (irq)
  );
  always #50 clk = ~clk;
  // --------
  // tasks
  // --------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr32(input logic [11:0] a, input logic [31:0] x);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= x;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go(input logic [2:0] p, input logic [2:0] m, input logic [4:0] e);
    @(posedge clk);
    pul <= p;
    @(posedge clk);
    pul <= 3'h0;
    tick(2);
    chk("mode", 32'(m), 32'(mode));
    chk("gate", 32'(e), 32'(gen));
    chk("uclk", 32'(e), 32'(uclk));
  endtask
  function automatic logic [31:0] msk(input logic [11:0] a);
    msk = a[2] ? 32'h0308_0000 : 32'h0000_0048;
  endfunction
  function automatic logic [4:0] gates(input logic [31:0] a, input logic [31:0] b);
    gates = {b[19], b[25], b[24], a[3], a[6]};
  endfunction
  // --------
  // tests
  // --------
  initial
  begin
    d = $urandom(69749);
    tick(6);
    rst_b <= 1'b1;
    tick(3);
    chk("gate", 32'h1, 32'(gen));
    chk("mode", 32'h1, 32'(mode));
    for (k = 0; k < 9; k++)
      rchk(ofs[k], (k % 2 == 0 && k < 6) ? 32'h40 : 32'h0);
    wr32(12'h200, 32'hffff_ffff);
    rchk(12'h200, 32'h0);
    $display("test reset done");
    for (k = 0; k < 30; k++)
    begin
      v = (k < 6) ? 32'hffff_ffff : $urandom;
      wr32(ofs[k % 6], v);
      sh[k % 6] = v & msk(ofs[k % 6]);
      rchk(ofs[k % 6], sh[k % 6]);
    end
    tick(1);
    chk("gate", 32'(gates(sh[0], sh[1])), 32'(gen));
    $display("test registers done");
    wr32(12'h100, 32'h0);
    rchk(12'h100, 32'h0);
    wr32(12'h100, rdata | 32'h8);
    wr32(12'h104, 32'h0308_0000);
    wr32(12'h154, 32'h0);
    wr32(12'h150, 32'h1f);
    acc <= 5'h1f;
    tick(1);
    chk("fault", 32'h1, 32'(flt));
    chk("ack", 32'h1e, 32'(ack));
    acc <= 5'h0;
    rchk(12'h150, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    wr32(12'h154, 32'h1);
    tick(1);
    chk("irq", 32'h1, 32'(irq));
    wr32(12'h150, 32'h1);
    tick(1);
    chk("irq", 32'h0, 32'(irq));
    $display("test faults done");
    wr32(12'h120, 32'h8);
    wr32(12'h124, 32'h0100_0000);
    wr32(12'h110, 32'h40);
    wr32(12'h114, 32'h0200_0000);
    go(3'h2, 3'h4, 5'h1e);
    go(3'h4, 3'h1, 5'h1e);
    wr32(12'h140, 32'h1);
    go(3'h2, 3'h4, 5'h06);
    wr32(12'h120, 32'h40);
    acc <= 5'h02;
    tick(1);
    chk("gate", 32'h05, 32'(gen));
    chk("fault", 32'h02, 32'(flt));
    acc <= 5'h0;
    go(3'h4, 3'h1, 5'h1e);
    go(3'h1, 3'h2, 5'h09);
    go(3'h4, 3'h1, 5'h1e);
    go(3'h3, 3'h4, 5'h05);
    go(3'h4, 3'h1, 5'h1e);
    $display("test modes done");
    tally_and_finish();
  end
endmodule
bind pcg_top pcg_chk i_chk (
  .i_clock       (i_clock),
  .i_rst_b       (i_rst_b),
  .i_addr        (i_addr),
  .i_wdata       (i_wdata),
  .i_wr          (i_wr),
  .i_rd          (i_rd),
  .o_rdata       (o_rdata),
  .i_sleep_enter (i_sleep_enter),
  .i_deep_enter  (i_deep_enter),
  .i_wake        (i_wake),
  .i_unit_access (i_unit_access),
  .o_bus_fault   (o_bus_fault),
  .o_unit_ack    (o_unit_ack),
  .o_gate_en     (o_gate_en),
  .o_unit_clock  (o_unit_clock),
  .o_mode        (o_mode),
  .o_irq         (o_irq)
);
`default_nettype wire
